// file: rtl/mdc_consts.vh
// Constants for the multiply/divide control and constant registers
`ifndef MDC_CONSTS_VH
`define MDC_CONSTS_VH

// Special function register byte addresses
`define MDC_ADDR_CTRL      16'hFE0E
`define MDC_ADDR_HIGH      16'hFE20
`define MDC_ADDR_LOW       16'hFE22
`define MDC_ADDR_ONES      16'hFE24
`define MDC_ADDR_ZEROS     16'hFE26

// Control register field positions
`define MDC_STEP_LSB       0
`define MDC_STEP_MSB       3
`define MDC_INUSE_BIT      4
`define MDC_KIND_LSB       5
`define MDC_KIND_MSB       6
`define MDC_BUSY_BIT       7
`define MDC_INT_MASK       16'h00EF
`define MDC_LIVE_MASK      16'h00FF

// Reset and fixed values
`define MDC_CTRL_RESET     16'h0000
`define MDC_HIGH_RESET     16'h0000
`define MDC_LOW_RESET      16'h0000
`define MDC_ALL_ONES       16'hFFFF
`define MDC_ALL_ZEROS      16'h0000

// Operation kinds
`define MDC_KIND_MUL       2'h0
`define MDC_KIND_DIV       2'h1
`define MDC_KIND_DIVL      2'h2

// Last step index of a 16-step operation
`define MDC_LAST_STEP      4'hF

`endif

// file: rtl/mdc_step.v
// One iteration of the shift-add multiply or restoring divide
`timescale 1ns/1ns
`include "mdc_consts.vh"

module mdc_step #(
	parameter W = 16
) (
	input  wire [1:0]   kind,
	input  wire [W-1:0] hi,
	input  wire [W-1:0] lo,
	input  wire [W-1:0] operand,
	output reg  [W-1:0] next_hi,
	output reg  [W-1:0] next_lo
);

	reg [W:0] sum;
	reg [W:0] rem;

	// Multiply shifts the partial product right; divide shifts the remainder left
	always @* begin
		sum = {1'b0, hi} + (lo[0] ? {1'b0, operand} : {(W+1){1'b0}});
		rem = {hi, lo[W-1]};
		if (kind == `MDC_KIND_MUL) begin
			next_hi = sum[W:1];
			next_lo = {sum[0], lo[W-1:1]};
		end else if (rem >= {1'b0, operand}) begin
			next_hi = rem[W-1:0] - operand;
			next_lo = {lo[W-2:0], 1'b1};
		end else begin
			next_hi = rem[W-1:0];
			next_lo = {lo[W-2:0], 1'b0};
		end
	end

endmodule

// file: rtl/mdc_regs.v
// Multiply/divide control register, result registers and constant registers
// What this block does
// - Control register is 16 bits, reachable by word writes and single-bit writes.
// - Hardware updates the control register every cycle of a running multiply or divide that MD_HOLD does not stall.
// - In-use flag bit 4 sets on result-register writes and on each operation start.
// - A software read of the low result register clears the in-use flag.
// - Bits 3..0 and 7..5 hold internal sequencing state of the operation.
// - Control register resets to all zeros.
// - All-ones constant register reads all ones, read-only, bit-addressable.
// - All-zeros constant register reads all zeros, read-only, bit-addressable.
// - Both constants are readable through the ordinary register read port.
// - High result holds product upper half after multiply, remainder after divide.
// - Low result holds product lower half after multiply, quotient after divide.
`timescale 1ns/1ns
`include "mdc_consts.vh"

module mdc_regs #(
	parameter W = 16
) (
	input  wire         CLK,
	input  wire         SRST,
	input  wire [15:0]  SFR_ADDR,
	input  wire         SFR_RD,
	input  wire         SFR_WR,
	input  wire [W-1:0] SFR_WDATA,
	input  wire         SFR_BIT_WR,
	input  wire [3:0]   SFR_BIT_SEL,
	input  wire         SFR_BIT_VAL,
	output reg  [W-1:0] SFR_RDATA,
	output reg          SFR_HIT,
	input  wire         MD_START,
	input  wire [1:0]   MD_KIND,
	input  wire         MD_HOLD,
	input  wire [W-1:0] MD_SRC1,
	input  wire [W-1:0] MD_SRC2,
	output wire         MD_BUSY,
	output reg          MD_DONE,
	output wire [W-1:0] MD_HIGH,
	output wire [W-1:0] MD_LOW
);

	reg  [W-1:0] ctrl;
	reg  [W-1:0] res_hi;
	reg  [W-1:0] res_lo;
	reg  [W-1:0] next_ctrl;
	reg  [W-1:0] next_hi;
	reg  [W-1:0] next_lo;
	reg          next_done;
	reg  [W-1:0] next_rdata;
	reg          next_hit;
	reg  [3:0]   step;
	reg  [1:0]   kind;
	reg          busy;
	reg          resume;
	reg          run;
	reg  [W-1:0] run_hi;
	reg  [W-1:0] run_lo;
	wire [W-1:0] step_hi;
	wire [W-1:0] step_lo;
	wire         wr_ctrl;
	wire         wr_hi;
	wire         wr_lo;
	wire         bit_ctrl;
	wire         rd_lo;

	// Address match for a word or bit access to one register
	function hit;
		input [15:0] addr;
		input [15:0] reg_addr;
		begin
			hit = (addr == reg_addr);
		end
	endfunction

	// New word after a word write or a single-bit write
	function [W-1:0] merge;
		input [W-1:0] old;
		input         word_wr;
		input [W-1:0] wdata;
		input [3:0]   sel;
		input         val;
		reg   [W-1:0] tmp;
		begin
			tmp = old;
			if (word_wr) begin
				tmp = wdata;
			end else begin
				tmp[sel] = val;
			end
			merge = tmp;
		end
	endfunction

	// Decoded software accesses; bit writes reach only bit-addressable registers
	assign wr_ctrl  = SFR_WR && hit(SFR_ADDR, `MDC_ADDR_CTRL);
	assign bit_ctrl = SFR_BIT_WR && hit(SFR_ADDR, `MDC_ADDR_CTRL);
	assign wr_hi    = SFR_WR && hit(SFR_ADDR, `MDC_ADDR_HIGH);
	assign wr_lo    = SFR_WR && hit(SFR_ADDR, `MDC_ADDR_LOW);
	assign rd_lo    = SFR_RD && hit(SFR_ADDR, `MDC_ADDR_LOW);

	assign MD_BUSY = ctrl[`MDC_BUSY_BIT];
	assign MD_HIGH = res_hi;
	assign MD_LOW  = res_lo;

	// Stepping state and the operand registers it works on
	always @* begin
		step   = ctrl[`MDC_STEP_MSB:`MDC_STEP_LSB];
		kind   = ctrl[`MDC_KIND_MSB:`MDC_KIND_LSB];
		busy   = ctrl[`MDC_BUSY_BIT];
		// A restored busy state of the same kind picks up where it stopped
		resume = busy && (kind == MD_KIND);
		run_hi = res_hi;
		run_lo = res_lo;
		if (MD_START && !resume) begin
			// Fresh start seeds the working pair; long divide keeps the dividend
			case (MD_KIND)
				`MDC_KIND_MUL: begin
					run_hi = {W{1'b0}};
					run_lo = MD_SRC1;
				end
				`MDC_KIND_DIV: begin
					run_hi = {W{1'b0}};
					run_lo = MD_SRC1;
				end
				default: begin
					run_hi = res_hi;
					run_lo = res_lo;
				end
			endcase
		end
		run = (MD_START || busy) && !MD_HOLD;
	end

	mdc_step #(
		.W       (W)
	) u_step (
		.kind    (MD_START ? MD_KIND : kind),
		.hi      (run_hi),
		.lo      (run_lo),
		.operand (MD_SRC2),
		.next_hi (step_hi),
		.next_lo (step_lo)
	);

	// Next control word, result pair and completion pulse
	always @* begin
		next_ctrl = ctrl;
		next_hi   = res_hi;
		next_lo   = res_lo;
		next_done = 1'b0;
		if (run) begin
			next_hi = step_hi;
			next_lo = step_lo;
			// step count, kind and busy fields
			if (MD_START && !resume) begin
				next_ctrl[`MDC_STEP_MSB:`MDC_STEP_LSB] = 4'h1;
				next_ctrl[`MDC_KIND_MSB:`MDC_KIND_LSB] = MD_KIND;
				next_ctrl[`MDC_BUSY_BIT] = 1'b1;
			end else if (step == `MDC_LAST_STEP) begin
				// high half or remainder now final
				// low half or quotient now final
				next_ctrl[`MDC_STEP_MSB:`MDC_STEP_LSB] = 4'h0;
				next_ctrl[`MDC_KIND_MSB:`MDC_KIND_LSB] = 2'h0;
				next_ctrl[`MDC_BUSY_BIT] = 1'b0;
				next_done = 1'b1;
			end else begin
				next_ctrl[`MDC_STEP_MSB:`MDC_STEP_LSB] = step + 4'h1;
			end
		end
		// word or bit write to control
		if (wr_ctrl || bit_ctrl) begin
			next_ctrl = merge(ctrl, wr_ctrl, SFR_WDATA, SFR_BIT_SEL, SFR_BIT_VAL);
		end
		next_ctrl = next_ctrl & `MDC_LIVE_MASK;
		if (wr_hi) begin
			next_hi = SFR_WDATA;
		end
		if (wr_lo) begin
			next_lo = SFR_WDATA;
		end
		// reading the low result clears the flag
		if (rd_lo) begin
			next_ctrl[`MDC_INUSE_BIT] = 1'b0;
		end
		// result writes and operation starts set the flag, winning over a clear
		if (wr_hi || wr_lo || (MD_START && !MD_HOLD)) begin
			next_ctrl[`MDC_INUSE_BIT] = 1'b1;
		end
	end

	// Read mux; unmapped addresses answer zero with no hit
	always @* begin
		next_rdata = {W{1'b0}};
		next_hit   = 1'b1;
		if (hit(SFR_ADDR, `MDC_ADDR_CTRL)) begin
			next_rdata = ctrl;
		end else if (hit(SFR_ADDR, `MDC_ADDR_HIGH)) begin
			next_rdata = res_hi;
		end else if (hit(SFR_ADDR, `MDC_ADDR_LOW)) begin
			next_rdata = res_lo;
		end else if (hit(SFR_ADDR, `MDC_ADDR_ONES)) begin
			next_rdata = `MDC_ALL_ONES;
		end else if (hit(SFR_ADDR, `MDC_ADDR_ZEROS)) begin
			next_rdata = `MDC_ALL_ZEROS;
		end else begin
			next_hit = 1'b0;
		end
	end

	// State registers; writes to the constants reach nothing here
	always @(posedge CLK) begin
		if (SRST) begin
			ctrl    <= `MDC_CTRL_RESET;
			res_hi  <= `MDC_HIGH_RESET;
			res_lo  <= `MDC_LOW_RESET;
			MD_DONE <= 1'b0;
		end else begin
			ctrl    <= next_ctrl;
			res_hi  <= next_hi;
			res_lo  <= next_lo;
			MD_DONE <= next_done;
		end
	end

	// Read data registered so it lands the cycle after the strobe
	always @(posedge CLK) begin
		if (SRST) begin
			SFR_RDATA <= {W{1'b0}};
			SFR_HIT   <= 1'b0;
		end else if (SFR_RD) begin
			SFR_RDATA <= next_rdata;
			SFR_HIT   <= next_hit;
		end else begin
			SFR_RDATA <= {W{1'b0}};
			SFR_HIT   <= 1'b0;
		end
	end

endmodule

// file: sim/mdc_chk.sv
// Checker for the control and constant registers
`timescale 1ns/1ns
`include "mdc_consts.vh"
module mdc_chk #(
	parameter W = 16
) (
	input wire         CLK,
	input wire         SRST,
	input wire [15:0]  SFR_ADDR,
	input wire         SFR_RD,
	input wire         SFR_WR,
	input wire         SFR_BIT_WR,
	input wire [W-1:0] SFR_RDATA,
	input wire         SFR_HIT,
	input wire         MD_START,
	input wire         MD_HOLD,
	input wire         MD_BUSY,
	input wire         MD_DONE,
	input wire [W-1:0] MD_LOW
);
	default clocking cb @(posedge CLK); endclocking
	default disable iff (SRST);
	// Decoded control reads, result writes and low reads
	wire rd_c = SFR_RD && SFR_ADDR == `MDC_ADDR_CTRL;
	wire wr_r = SFR_WR && (SFR_ADDR == `MDC_ADDR_HIGH || SFR_ADDR == `MDC_ADDR_LOW);
	wire rd_l = SFR_RD && SFR_ADDR == `MDC_ADDR_LOW && !SFR_WR && !MD_START && !MD_BUSY;
	property p_rst; $fell(SRST) |-> !MD_BUSY && !MD_DONE && MD_LOW == 0; endproperty
	a_rst: assert property (p_rst) else $error("not clear after reset");
	property p_one; SFR_RD && SFR_ADDR == `MDC_ADDR_ONES |=> SFR_HIT && &SFR_RDATA; endproperty
	a_one: assert property (p_one) else $error("ones read wrong");
	property p_zer; SFR_RD && SFR_ADDR == `MDC_ADDR_ZEROS |=> SFR_HIT && SFR_RDATA == 0; endproperty
	a_zer: assert property (p_zer) else $error("zeros read wrong");
	property p_idle; !SFR_RD |=> !SFR_HIT && SFR_RDATA == 0; endproperty
	a_idle: assert property (p_idle) else $error("read port not idle");
	property p_rsv; rd_c |=> SFR_HIT && SFR_RDATA[15:8] == 0; endproperty
	a_rsv: assert property (p_rsv) else $error("upper control bits set");
	property p_set;
		wr_r ##1 (!SFR_RD && !SFR_WR && !SFR_BIT_WR) ##1 rd_c |=> SFR_RDATA[4];
	endproperty
	a_set: assert property (p_set) else $error("in-use flag not set");
	property p_clr;
		rd_l ##1 (!SFR_WR && !SFR_BIT_WR && !MD_START) ##1 rd_c && !SFR_WR && !MD_START
			|=> !SFR_RDATA[4];
	endproperty
	a_clr: assert property (p_clr) else $error("in-use flag not cleared");
	property p_busy; MD_START && !MD_HOLD && !MD_BUSY |=> MD_BUSY [*8]; endproperty
	a_busy: assert property (p_busy) else $error("busy dropped early");
	property p_done;
		MD_START && !MD_HOLD && !MD_BUSY ##1 !MD_HOLD [*8] ##1 !MD_HOLD [*7] |=> MD_DONE;
	endproperty
	a_done: assert property (p_done) else $error("done not after 16 steps");
	property p_pul; MD_DONE |=> !MD_DONE; endproperty
	a_pul: assert property (p_pul) else $error("done longer than a cycle");
endmodule
bind mdc_regs mdc_chk #(.W(W)) u_chk (.CLK(CLK), .SRST(SRST), .SFR_ADDR(SFR_ADDR),
	.SFR_RD(SFR_RD), .SFR_WR(SFR_WR), .SFR_BIT_WR(SFR_BIT_WR),
	.SFR_RDATA(SFR_RDATA), .SFR_HIT(SFR_HIT),
	.MD_START(MD_START), .MD_HOLD(MD_HOLD), .MD_BUSY(MD_BUSY), .MD_DONE(MD_DONE), .MD_LOW(MD_LOW));

// file: sim/tb.sv
// Self-checking bench for the control and constant registers
`timescale 1ns/1ns
`include "mdc_consts.vh"
module tb;
	logic        CLK = 0, SRST = 1, RD = 0, WR = 0, BW = 0, BV = 0, ST = 0, HD = 0;
	logic [15:0] A = 0, WD = 0, S1 = 0, S2 = 0, RDATA, HI, LO, sc, sh, sl;
	logic [3:0]  BS = 0;
	logic [1:0]  KD = 0;
	logic        HIT, BUSY, DONE;
	int          mismatches = 0, cmp_count = 0, n;
	logic [15:0] ra [6] = '{`MDC_ADDR_CTRL, `MDC_ADDR_HIGH, `MDC_ADDR_LOW, `MDC_ADDR_ONES,
		`MDC_ADDR_ZEROS, 16'hFE30};
	logic [15:0] rx [6] = '{16'h0000, 16'h0000, 16'h0000, 16'hFFFF, 16'h0000, 16'h0000};
	mdc_regs dut (.CLK(CLK), .SRST(SRST), .SFR_ADDR(A), .SFR_RD(RD), .SFR_WR(WR),
		.SFR_WDATA(WD), .SFR_BIT_WR(BW), .SFR_BIT_SEL(BS), .SFR_BIT_VAL(BV),
		.SFR_RDATA(RDATA), .SFR_HIT(HIT), .MD_START(ST), .MD_KIND(KD), .MD_HOLD(HD),
		.MD_SRC1(S1), .MD_SRC2(S2), .MD_BUSY(BUSY), .MD_DONE(DONE), .MD_HIGH(HI), .MD_LOW(LO));
	// 50 ns clock
	initial forever #25 CLK = ~CLK;
	task automatic chk(input logic [31:0] got, exp);
		cmp_count++;
		if (got !== exp) begin
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
			mismatches++;
		end
	endtask
	task automatic end_sim;
		$display("compares %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// Read is answered in the cycle after the strobe, masked to the bits of interest
	task automatic rd(input logic [15:0] a, e, m, input logic h);
		@(posedge CLK);
		A <= a;
		RD <= 1;
		@(posedge CLK);
		RD <= 0;
		#1;
		chk({HIT, RDATA & m}, {h, e});
	endtask
	task automatic wr(input logic [15:0] a, d, input logic b);
		@(posedge CLK);
		A <= a;
		WD <= d;
		BS <= d[3:0];
		BV <= d[4];
		WR <= !b;
		BW <= b;
		@(posedge CLK);
		WR <= 0;
		BW <= 0;
	endtask
	// Hold is raised after the third step edge for h cycles, stretching the run
	task automatic op(input logic [1:0] k, input logic [15:0] s1, s2, input int h,
		input logic [31:0] e);
		@(posedge CLK);
		KD <= k;
		S1 <= s1;
		S2 <= s2;
		ST <= 1;
		for (n = 1; n < 40; n++) begin
			@(posedge CLK);
			ST <= 0;
			HD <= (n >= 3 && n < 3 + h);
			#1;
			if (DONE === 1'b1)
				break;
		end
		chk(n, 16 + h);
		chk({HI, LO}, e);
		$display("op kind %0d end", k);
		if (n == 40)
			end_sim;
	endtask
	initial begin
		repeat (16) @(posedge CLK);
		SRST <= 0;
		for (int i = 0; i < 6; i++)
			rd(ra[i], rx[i], 16'hFFFF, i < 5);
		$display("reset rows end");
		wr(`MDC_ADDR_ONES, 16'h0000, 0);
		wr(`MDC_ADDR_ZEROS, 16'hFFFF, 0);
		rd(`MDC_ADDR_ONES, 16'hFFFF, 16'hFFFF, 1);
		rd(`MDC_ADDR_ZEROS, 16'h0000, 16'hFFFF, 1);
		wr(`MDC_ADDR_HIGH, 16'h00AA, 0);
		rd(`MDC_ADDR_CTRL, 16'h0010, 16'h0010, 1);
		rd(`MDC_ADDR_HIGH, 16'h00AA, 16'hFFFF, 1);
		rd(`MDC_ADDR_LOW, 16'h0000, 16'hFFFF, 1);
		rd(`MDC_ADDR_CTRL, 16'h0000, 16'h0010, 1);
		wr(`MDC_ADDR_CTRL, 16'h0019, 1);
		wr(`MDC_ADDR_CTRL, 16'h0014, 1);
		rd(`MDC_ADDR_CTRL, 16'h0010, 16'hFFFF, 1);
		wr(`MDC_ADDR_CTRL, 16'hFF00, 0);
		rd(`MDC_ADDR_CTRL, 16'h0000, 16'hFFFF, 1);
		$display("register tests end");
		op(0, 16'h1234, 16'h5678, 0, 32'h1234 * 32'h5678);
		rd(`MDC_ADDR_CTRL, 16'h0010, 16'h0010, 1);
		op(0, 16'hFFFF, 16'hFFFF, 3, 32'hFFFF * 32'hFFFF);
		op(1, 16'h1234, 16'h0007, 0, {16'h1234 % 16'h0007, 16'h1234 / 16'h0007});
		wr(`MDC_ADDR_HIGH, 16'h0001, 0);
		wr(`MDC_ADDR_LOW, 16'h0003, 0);
		op(2, 16'h0000, 16'h0100, 0, {16'h0003, 16'h0100});
		@(posedge CLK);
		KD <= 0;
		S1 <= 16'hABCD;
		S2 <= 16'h0123;
		ST <= 1;
		@(posedge CLK);
		ST <= 0;
		@(posedge CLK);
		HD <= 1;
		// Busy, kind multiply, flag set, two steps done
		rd(`MDC_ADDR_CTRL, 16'h0092, 16'hFFFF, 1);
		sc = RDATA;
		rd(`MDC_ADDR_HIGH, 16'h0000, 16'h0000, 1);
		sh = RDATA;
		rd(`MDC_ADDR_LOW, 16'h0000, 16'h0000, 1);
		sl = RDATA;
		wr(`MDC_ADDR_CTRL, 16'h0000, 0);
		HD <= 0;
		op(1, 16'h0064, 16'h0007, 0, {16'h0002, 16'h000E});
		S2 <= 16'h0123;
		wr(`MDC_ADDR_HIGH, sh, 0);
		wr(`MDC_ADDR_LOW, sl, 0);
		wr(`MDC_ADDR_CTRL, sc, 0);
		KD <= 0;
		ST <= 1;
		// Fourteen steps remain; a fresh reseed would take sixteen and finish late
		for (n = 1; n < 40; n++) begin
			@(posedge CLK);
			ST <= 0;
			#1;
			if (DONE === 1'b1)
				break;
		end
		chk(n, 14);
		chk({HI, LO}, 32'hABCD * 32'h0123);
		$display("resume test end");
		@(posedge CLK);
		S1 <= 16'h00FF;
		ST <= 1;
		@(posedge CLK);
		ST <= 0;
		repeat (3) @(posedge CLK);
		SRST <= 1;
		repeat (2) @(posedge CLK);
		SRST <= 0;
		#1;
		chk({BUSY, DONE, HI}, 18'h00000);
		rd(`MDC_ADDR_CTRL, 16'h0000, 16'hFFFF, 1);
		rd(`MDC_ADDR_LOW, 16'h0000, 16'hFFFF, 1);
		$display("mid-run reset end");
		end_sim;
	end
endmodule
